// *** src/acr_result_window.sv ***
// result register, window thresholds, shared byte latch and clock shape bit
// assumes an apb master on pclk and a converter delivering one sample pulse at a time
//
// Behaviour
// R1: one shared 8-bit latch for 16-bit registers
// R2: low byte at base, high byte at base+1
// R3: sample saturates high, zero below ground
// R4: up to 64 samples, sum never above ceiling
// R5: window compare uses final accumulated value
// R6: codes rise from zero to full scale
// R7: raw 10-bit code in result bits 9:0
// R8: result at 0x10, reset zero, read only
// R9: low threshold at 0x12, writable, reset zero
// R10: high threshold at 0x14, writable, reset zero
// R11: duty bit selects 50% or 25% clock
// R12: result read or write-one clears flags
// R13: window mode codes none/below/above/inside/outside
// R14: low read latches high; low write held
`timescale 1ns/1ps
`include "acr_regs.svh"
module acr_result_window
   import acr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire acr_sample_t sample,
   input wire acr_accum_cfg_t accum_cfg,
   output logic clock_duty_select,
   output logic result_ready_flag,
   output logic window_match_flag,
   output logic [15:0] conversion_result
);
   // ****************************************
   // bus decode
   // ****************************************
   // every register answers in the first access cycle, so pready is constant high;
   // each byte register sits in its own aligned word at byte address = offset * 4
   logic acc;
   logic wr;
   logic rd;
   logic [7:0] off;
   logic hit;
   assign acc = psel & penable;
   assign wr = acc & pwrite;
   assign rd = acc & ~pwrite;
   assign off = {2'b00, paddr[7:2]};
   assign pready = 1'b1;
   always_comb begin
      unique case (off)
         `ACR_OFF_FLAGS, `ACR_OFF_TEMP, `ACR_OFF_MODE: hit = 1'b1;
         `ACR_OFF_RES, `ACR_OFF_RES + `ACR_HI_STEP: hit = 1'b1;
         `ACR_OFF_WINDOW_LOW_LIMIT, `ACR_OFF_WINDOW_LOW_LIMIT + `ACR_HI_STEP: hit = 1'b1;
         `ACR_OFF_WINDOW_HIGH_LIMIT, `ACR_OFF_WINDOW_HIGH_LIMIT + `ACR_HI_STEP: hit = 1'b1;
         `ACR_OFF_SHAPE: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   assign pslverr = acc & ~hit;
   // ****************************************
   // state
   // ****************************************
   logic [7:0] temp_r, temp_nxt;
   logic [15:0] res_r, res_nxt;
   logic [15:0] window_low_limit_r, window_low_limit_nxt;
   logic [15:0] window_high_limit_r, window_high_limit_nxt;
   logic [7:0] shape_r, shape_nxt;
   logic [2:0] mode_r, mode_nxt;
   logic rdy_r, rdy_nxt;
   logic win_r, win_nxt;
   logic [15:0] sum_r, sum_nxt;
   logic [6:0] cnt_r, cnt_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [9:0] sat_code;
   logic [15:0] sum_add;
   logic [6:0] target;
   logic done;
   logic match;
   // saturate the raw code; the analog flags win over a stale code
   always_comb begin
      if (sample.over_ref) begin
         sat_code = `ACR_RAW_MAX; // see R3
      end else if (sample.under_gnd) begin
         sat_code = `ACR_RAW_MIN; // see R3
      end else begin
         sat_code = sample.code;
      end
   end
   // zero or one in the count both mean a single sample; counts above 64 are clamped
   always_comb begin
      if (accum_cfg.count == 7'h00) begin
         target = 7'h01;
      end else if (accum_cfg.count > `ACR_ACC_CNT_MAX) begin
         target = `ACR_ACC_CNT_MAX; // see R4
      end else begin
         target = accum_cfg.count;
      end
   end
   // 64 x 0x3FF stays below 0x10000, so no carry out is possible
   assign sum_add = sum_r + {6'h00, sat_code}; // see R4 see R7
   assign done = sample.valid & ((cnt_r + 7'h01) >= target);
   // unsigned compare is correct since codes rise monotonically
   always_comb begin
      unique case (mode_r)
         ACR_WIN_NONE: match = 1'b0; // see R13
         ACR_WIN_BELOW: match = sum_add < window_low_limit_r; // see R6
         ACR_WIN_ABOVE: match = sum_add > window_high_limit_r;
         ACR_WIN_INSIDE: match = (sum_add > window_low_limit_r) && (sum_add < window_high_limit_r);
         ACR_WIN_OUTSIDE: match = (sum_add < window_low_limit_r) || (sum_add > window_high_limit_r);
         default: match = 1'b0; // reserved codes never match
      endcase
   end
   // ****************************************
   // next-state logic
   // ****************************************
   always_comb begin
      temp_nxt = temp_r;
      res_nxt = res_r;
      window_low_limit_nxt = window_low_limit_r;
      window_high_limit_nxt = window_high_limit_r;
      shape_nxt = shape_r;
      mode_nxt = mode_r;
      rdy_nxt = rdy_r;
      win_nxt = win_r;
      sum_nxt = sum_r;
      cnt_nxt = cnt_r;
      rdata_nxt = 32'h0000_0000;
      // software side first; hardware sets below override clears
      if (wr) begin
         unique case (off)
            `ACR_OFF_FLAGS: begin
               if (pwdata[`ACR_FLG_RDY]) rdy_nxt = 1'b0; // see R12
               if (pwdata[`ACR_FLG_WIN]) win_nxt = 1'b0; // see R12
            end
            `ACR_OFF_TEMP: temp_nxt = pwdata[7:0]; // see R1
            `ACR_OFF_MODE: mode_nxt = pwdata[2:0];
            `ACR_OFF_WINDOW_LOW_LIMIT, `ACR_OFF_WINDOW_HIGH_LIMIT: temp_nxt = pwdata[7:0]; // see R14
            `ACR_OFF_WINDOW_LOW_LIMIT + `ACR_HI_STEP: window_low_limit_nxt = {pwdata[7:0], temp_r}; // see R9 see R14
            `ACR_OFF_WINDOW_HIGH_LIMIT + `ACR_HI_STEP: window_high_limit_nxt = {pwdata[7:0], temp_r}; // see R10
            `ACR_OFF_SHAPE: shape_nxt = pwdata[7:0]; // see R11
            default: ; // result is read only; see R8
         endcase
      end
      if (rd) begin
         unique case (off)
            `ACR_OFF_FLAGS: rdata_nxt = {30'h0, win_r, rdy_r};
            `ACR_OFF_TEMP: rdata_nxt = {24'h0, temp_r};
            `ACR_OFF_MODE: rdata_nxt = {29'h0, mode_r};
            `ACR_OFF_RES: begin
               rdata_nxt = {24'h0, res_r[7:0]}; // see R2
               temp_nxt = res_r[15:8]; // see R14
               rdy_nxt = 1'b0; // see R12
               win_nxt = 1'b0;
            end
            `ACR_OFF_WINDOW_LOW_LIMIT: begin
               rdata_nxt = {24'h0, window_low_limit_r[7:0]};
               temp_nxt = window_low_limit_r[15:8];
            end
            `ACR_OFF_WINDOW_HIGH_LIMIT: begin
               rdata_nxt = {24'h0, window_high_limit_r[7:0]};
               temp_nxt = window_high_limit_r[15:8];
            end
            `ACR_OFF_RES + `ACR_HI_STEP, `ACR_OFF_WINDOW_LOW_LIMIT + `ACR_HI_STEP,
            `ACR_OFF_WINDOW_HIGH_LIMIT + `ACR_HI_STEP: begin
               rdata_nxt = {24'h0, temp_r}; // see R2 see R14
            end
            `ACR_OFF_SHAPE: rdata_nxt = {24'h0, shape_r};
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
      // accumulate; flags are compared against the final sum only
      if (sample.valid) begin
         if (done) begin
            res_nxt = sum_add; // see R5 see R8
            sum_nxt = 16'h0000;
            cnt_nxt = 7'h00;
            rdy_nxt = 1'b1;
            if (match) win_nxt = 1'b1; // see R5
         end else begin
            sum_nxt = sum_add;
            cnt_nxt = cnt_r + 7'h01;
         end
      end
   end
   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         temp_r <= 8'h00;
         res_r <= 16'h0000;
         window_low_limit_r <= 16'h0000;
         window_high_limit_r <= 16'h0000;
         shape_r <= `ACR_SHAPE_RST;
         mode_r <= 3'h0;
         rdy_r <= 1'b0;
         win_r <= 1'b0;
         sum_r <= 16'h0000;
         cnt_r <= 7'h00;
         rdata_r <= 32'h0000_0000;
      end else begin
         temp_r <= temp_nxt;
         res_r <= res_nxt;
         window_low_limit_r <= window_low_limit_nxt;
         window_high_limit_r <= window_high_limit_nxt;
         shape_r <= shape_nxt;
         mode_r <= mode_nxt;
         rdy_r <= rdy_nxt;
         win_r <= win_nxt;
         sum_r <= sum_nxt;
         cnt_r <= cnt_nxt;
         rdata_r <= rdata_nxt;
      end
   end
   // read data must be valid in the access cycle, so it is decoded combinationally
   // from the flops; rdata_r only mirrors it for the checks below
   always_comb begin
      prdata = rdata_nxt;
   end
   assign clock_duty_select = shape_r[`ACR_DUTY_BIT]; // see R11
   assign result_ready_flag = rdy_r;
   assign window_match_flag = win_r;
   assign conversion_result = res_r;
   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_res_ceiling: assert property (res_r <= `ACR_ACC_MAX) // see R4
      else $error("result above accumulation ceiling");
   a_res_readonly: assert property ((wr && (off == `ACR_OFF_RES)) && !sample.valid
      |=> $stable(res_r)) // see R8
      else $error("result changed by a write");
   a_rd_clears: assert property ((rd && off == `ACR_OFF_RES) && !sample.valid
      |=> !rdy_r && !win_r) // see R12
      else $error("result read did not clear flags");
   a_zero_keeps: assert property ((wr && off == `ACR_OFF_FLAGS && pwdata[1:0] == 2'b00
      && !(rd) && !sample.valid) |=> $stable({rdy_r, win_r})) // see R12
      else $error("writing zero changed a flag");
   a_low_latch: assert property ((rd && off == `ACR_OFF_RES) |=>
      temp_r == $past(res_r[15:8])) // see R14
      else $error("high byte not latched");
   a_lt_pair: assert property ((wr && off == `ACR_OFF_WINDOW_LOW_LIMIT + `ACR_HI_STEP) |=>
      window_low_limit_r == {$past(pwdata[7:0]), $past(temp_r)}) // see R9
      else $error("low threshold pair mismatch");
   a_ht_pair: assert property ((wr && off == `ACR_OFF_WINDOW_HIGH_LIMIT + `ACR_HI_STEP) |=>
      window_high_limit_r == {$past(pwdata[7:0]), $past(temp_r)}) // see R10
      else $error("high threshold pair mismatch");
   a_none_nomatch: assert property ((done && mode_r == ACR_WIN_NONE && !win_r) |=>
      !win_r) // see R13
      else $error("match flagged with comparison off");
   a_done_ready: assert property (done |=> rdy_r && res_r == $past(sum_add)) // see R5
      else $error("final result not posted");
   a_duty_map: assert property (clock_duty_select == shape_r[0]) // see R11
      else $error("duty select mismatch");
   // ****************************************
   // sample path checks
   // ****************************************
   // a single-sample result starts from an empty sum, so the posted value is the
   // saturated code itself; this pins the clamp without reusing its expression
   sequence s_first_final;
      sample.valid && done && (cnt_r == 7'h00);
   endsequence
   sequence s_mid_sample;
      sample.valid && !done;
   endsequence
   a_over_clamp: assert property (s_first_final ##0 sample.over_ref |=>
      res_r == {6'h00, `ACR_RAW_MAX}) // see R3
      else $error("over-reference sample not clamped");
   a_under_zero: assert property (s_first_final ##0 (sample.under_gnd && !sample.over_ref)
      |=> res_r == {6'h00, `ACR_RAW_MIN}) // see R3
      else $error("below-ground sample not zero");
   a_raw_place: assert property (s_first_final ##0 (!sample.under_gnd && !sample.over_ref)
      |=> res_r == {6'h00, $past(sample.code)}) // see R7
      else $error("raw code not in low bits");
   // partial sums must never reach the visible result or the flags
   a_partial_hold: assert property (s_mid_sample ##0 !wr |=> $stable(res_r)
      && sum_r == $past(sum_add)) // see R5
      else $error("partial sum leaked to result");
   // ****************************************
   // bus side checks
   // ****************************************
   // writing a one clears a flag unless a finished sample sets it again
   a_w1_clears: assert property ((wr && off == `ACR_OFF_FLAGS && pwdata[`ACR_FLG_RDY]
      && !done) |=> !rdy_r) // see R12
      else $error("write one left ready set");
   // hardware set wins over a same-cycle clear
   a_set_wins: assert property ((wr && off == `ACR_OFF_FLAGS && done) |=> rdy_r) // see R12
      else $error("ready lost to a clear");
   a_err_unmapped: assert property ((acc && !hit) |-> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
   // the registered copy trails the bus data by one edge
   a_rdata_copy: assert property (rd |=> rdata_r == $past(prdata)) // see R2
      else $error("read data copy mismatch");
   a_res_low_rd: assert property ((rd && off == `ACR_OFF_RES) |->
      prdata == {24'h0, res_r[7:0]}) // see R2
      else $error("result low byte misread");
endmodule

// *** src/acr_regs.svh ***
// register offsets, field positions and reset values of the result/window block
// assumes inclusion by the design module only
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH
// byte register offsets inside the block (bus address bits [7:2] index the word)
`define ACR_OFF_FLAGS 8'h0B
`define ACR_OFF_TEMP 8'h0D
`define ACR_OFF_MODE 8'h0E
`define ACR_OFF_RES 8'h10
`define ACR_OFF_WINDOW_LOW_LIMIT 8'h12
`define ACR_OFF_WINDOW_HIGH_LIMIT 8'h14
`define ACR_OFF_SHAPE 8'h16
`define ACR_HI_STEP 8'h01
`define ACR_SHAPE_RST 8'h01
`define ACR_RAW_MAX 10'h3FF
`define ACR_RAW_MIN 10'h000
`define ACR_ACC_MAX 16'hFFC0
`define ACR_ACC_CNT_MAX 7'h40
`define ACR_FLG_RDY 0
`define ACR_FLG_WIN 1
`define ACR_DUTY_BIT 0
`endif

// *** src/acr_pkg.sv ***
// types shared by the result/window block
// assumes the register header sits beside it
package acr_pkg;
   typedef enum logic [2:0] {
      ACR_WIN_NONE = 3'h0,
      ACR_WIN_BELOW = 3'h1,
      ACR_WIN_ABOVE = 3'h2,
      ACR_WIN_INSIDE = 3'h3,
      ACR_WIN_OUTSIDE = 3'h4
   } acr_win_mode_t;
   // one finished conversion from the analog side
   typedef struct packed {
      logic valid;
      logic over_ref;
      logic under_gnd;
      logic [9:0] code;
   } acr_sample_t;
   // accumulation setup from the sequencer
   typedef struct packed {
      logic [6:0] count;
   } acr_accum_cfg_t;
endpackage

// *** test/tb_acr_result_window.sv ***
// self-checking bench for the result/window register block
// assumes a zero-wait apb slave whose byte address is four times the register index
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_acr_result_window;
   import acr_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, clock_duty_select, result_ready_flag, window_match_flag;
   logic [15:0] conversion_result;
   acr_sample_t sample = '0;
   acr_accum_cfg_t accum_cfg = 7'h01;
   int num_errors = 0;
   int compares = 0;
   logic [31:0] rd;
   logic [15:0] v;
   logic err;

   acr_result_window uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sample(sample), .accum_cfg(accum_cfg),
      .clock_duty_select(clock_duty_select), .result_ready_flag(result_ready_flag),
      .window_match_flag(window_match_flag), .conversion_result(conversion_result));

   // *****************************
   // bus and stimulus helpers
   // *****************************
   always #4 pclk = ~pclk;

   // one apb transfer; the request stands until the edge that sees pready high,
   // read data and error are taken at that very edge, then one idle edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // low byte first on both directions, as the shared latch expects
   task automatic wr16(input logic [7:0] a, input logic [15:0] d);
      apb(1'b1, a, d[7:0]);
      apb(1'b1, a + 8'h04, d[15:8]);
   endtask

   task automatic rd16(input logic [7:0] a);
      apb(1'b0, a, 8'h00);
      v[7:0] = rd[7:0];
      apb(1'b0, a + 8'h04, 8'h00);
      v[15:8] = rd[7:0];
   endtask

   // one-cycle sample pulse; the trailing edge keeps pulses apart
   task automatic smp(input logic [9:0] c, input logic o, input logic u);
      sample <= {1'b1, o, u, c};
      @(posedge pclk);
      sample <= '0;
      @(posedge pclk);
   endtask

   // *****************************
   // scenarios
   // *****************************
   task automatic t_reset;
      `CHK("duty", 1'b1, clock_duty_select)
      rd16(8'h40); `CHK("res", 16'h0000, v)
      rd16(8'h48); `CHK("winlo", 16'h0000, v)
      rd16(8'h50); `CHK("winhi", 16'h0000, v)
      apb(1'b0, 8'h58, 8'h00); `CHK("shape", 32'h00000001, rd)
      apb(1'b0, 8'h7C, 8'h00); `CHK("unmapped", 1'b1, err)
      apb(1'b1, 8'h34, 8'h5A);
      apb(1'b0, 8'h34, 8'h00); `CHK("latch", 32'h0000005A, rd)
      $display("test reset done");
   endtask

   task automatic t_pair;
      wr16(8'h48, 16'h0134);
      wr16(8'h50, 16'hFE02);
      rd16(8'h48); `CHK("winlo", 16'h0134, v)
      rd16(8'h50); `CHK("winhi", 16'hFE02, v)
      // a lone low write must wait in the latch until its high half arrives
      apb(1'b1, 8'h48, 8'h77);
      apb(1'b0, 8'h34, 8'h00); `CHK("held", 32'h00000077, rd)
      apb(1'b1, 8'h4C, 8'h01);
      rd16(8'h48); `CHK("commit", 16'h0177, v)
      $display("test pairing done");
   endtask

   task automatic t_sat;
      smp(10'h155, 1'b0, 1'b0); `CHK("raw", 16'h0155, conversion_result)
      smp(10'h000, 1'b1, 1'b0); `CHK("over", 16'h03FF, conversion_result)
      `CHK("rdy", 1'b1, result_ready_flag)
      smp(10'h155, 1'b0, 1'b1); `CHK("under", 16'h0000, conversion_result)
      apb(1'b1, 8'h40, 8'h55); `CHK("ro", 16'h0000, conversion_result)
      apb(1'b0, 8'h40, 8'h00); `CHK("rdclr", 1'b0, result_ready_flag)
      $display("test saturation done");
   endtask

   task automatic t_accum;
      accum_cfg <= 7'h40;
      repeat (63) smp(10'h000, 1'b1, 1'b0);
      `CHK("early", 1'b0, result_ready_flag)
      smp(10'h000, 1'b1, 1'b0); `CHK("ceil", 16'hFFC0, conversion_result)
      apb(1'b0, 8'h40, 8'h00); `CHK("lo", 32'h000000C0, rd)
      apb(1'b0, 8'h34, 8'h00); `CHK("copy", 32'h000000FF, rd)
      apb(1'b0, 8'h44, 8'h00); `CHK("hi", 32'h000000FF, rd)
      `CHK("rdclr", 1'b0, result_ready_flag)
      // each sample sits below the low limit, only the sum lands inside
      accum_cfg <= 7'h02;
      wr16(8'h48, 16'h0100);
      wr16(8'h50, 16'h0200);
      apb(1'b1, 8'h38, 8'h03);
      smp(10'h0C0, 1'b0, 1'b0); `CHK("part", 1'b0, window_match_flag)
      smp(10'h0C0, 1'b0, 1'b0); `CHK("sum", 1'b1, window_match_flag)
      apb(1'b1, 8'h2C, 8'h03);
      $display("test accumulation done");
   endtask

   task automatic t_modes;
      logic [9:0] c [3] = '{10'h050, 10'h150, 10'h250};
      logic [4:0] e [3] = '{5'b10010, 5'b01000, 5'b10100};
      accum_cfg <= 7'h01;
      for (int m = 0; m < 5; m++) begin
         apb(1'b1, 8'h38, 8'(m));
         for (int k = 0; k < 3; k++) begin
            smp(c[k], 1'b0, 1'b0);
            `CHK("match", e[k][m], window_match_flag)
            apb(1'b1, 8'h2C, 8'h00); `CHK("w0", 1'b1, result_ready_flag)
            apb(1'b1, 8'h2C, 8'h03); `CHK("w1", 1'b0, result_ready_flag)
            `CHK("w1win", 1'b0, window_match_flag)
         end
      end
      $display("test modes done");
   endtask

   task automatic t_duty;
      apb(1'b1, 8'h58, 8'h00); `CHK("duty0", 1'b0, clock_duty_select)
      apb(1'b1, 8'h58, 8'h01); `CHK("duty1", 1'b1, clock_duty_select)
      $display("test duty done");
   endtask

   task automatic wrap_up;
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // whole run is well under two thousand cycles
   initial begin
      #100000;
      num_errors++;
      wrap_up();
   end

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_pair();
      t_sat();
      t_accum();
      t_modes();
      t_duty();
      wrap_up();
   end
endmodule
